//--- logic/qdb_sram_port.sv
// Behaviour
// RULE1: read request low starts two-beat read burst
// RULE2: host spaces read requests two cycles apart
// RULE3: read beats launch two and three cycles later; the code launches beat 0 at the K# two and a half cycles later
// RULE4: echo clocks run free, aligned with data
// RULE5: idle cycle never truncates running read burst
// RULE6: write taken with first beat at rise
// RULE7: write address and second beat on inverted
// RULE8: host presents first beat before write address
// RULE9: buffered write commits on third write cycle; the code commits it at the K# of the next write
// RULE10: read of last write returns buffer data
// RULE11: read then same-address write returns newest data
// RULE12: byte lane low enables that beat's byte
// RULE13: no write request means no array write
// RULE14: impedance starts mid, settles within 1024 cycles
// RULE15: read and write ports work independently
// RULE16: pending transactions finish before port deselect
// RULE17: valid flag leads data by half cycle
// RULE18: second beat uses first address plus one
// RULE19: loop bypass pin gives one-cycle read latency
// RULE20: host drives requests valid at rising edge
// RULE21: read data undriven outside valid beats
// RULE22: each byte lane governs nine data bits
`include "qdb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module qdb_sram_port
    import qdb_pkg::*;
#(
    parameter int ADDR_W = `QDB_ADDR_W,     // burst address width
    parameter int DATA_W = `QDB_DATA_W,     // 36 or 18
    parameter int ZQ_CYC = `QDB_ZQ_CYCLES   // impedance settling cycles
)
(
    input  wire logic              clk,                 // system clock, impedance_ready synchroniser only
    input  wire logic              rst_n,               // async reset, active low
    input  wire logic              main_clock,          // link clock, both edges
    input  wire logic              main_clock_inverted, // complementary link clock
    input  wire logic              loop_bypass_n,       // low selects one cycle latency
    input  wire logic              read_request_n,      // read request, active low
    input  wire logic              write_request_n,     // write request, active low
    input  wire logic [ADDR_W-1:0] address_inputs,      // read addr at K, write addr at K#
    input  wire logic [DATA_W-1:0] write_data,          // ddr write data
    input  wire logic [DATA_W/9-1:0] byte_write_n,      // lane write enables, active low
    output logic [DATA_W-1:0]      read_data,           // read data value
    output logic                   read_data_oe,        // high while read_data driven
    output logic                   echo_clock,          // free running echo clock
    output logic                   echo_clock_inverted, // complementary echo clock
    output logic                   read_valid_flag,     // read data valid indicator
    output logic [3:0]             impedance_code,      // driver impedance setting
    output logic                   impedance_ready      // impedance calibrated, clk domain
);
    import qdb_pkg::*;

    localparam int LANES = DATA_W / 9;
    localparam int DEPTH = 1 << (ADDR_W + 1);

    // refuse sizes the lane split and the array cannot serve
    if (DATA_W != 36 && DATA_W != 18)
    begin
        $error("qdb_sram_port: DATA_W must be 18 or 36");
    end
    if (ADDR_W < 1 || ADDR_W > 22)
    begin
        $error("qdb_sram_port: ADDR_W out of range");
    end

    // =========================================================
    // storage and helpers
    logic [DATA_W-1:0] mem [DEPTH];

    // merge new beat into old word under lane enables
    function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_w,
                                                     input logic [DATA_W-1:0] new_w,
                                                     input logic [LANES-1:0]  ln_n);
        logic [DATA_W-1:0] r;
        r = old_w;
        for (int i = 0; i < LANES; i++)
            if (!ln_n[i])
                r[i*9 +: 9] = new_w[i*9 +: 9]; // see RULE12 see RULE22
        return r;
    endfunction

    // beat address: burst base with beat index in the low bit
    function automatic logic [ADDR_W:0] beat_addr(input logic [ADDR_W-1:0] a, input logic b);
        return {a, b}; // see RULE18
    endfunction

    // =========================================================
    // loop bypass strap, sampled in the link domain
    logic bypass_sync;

    qdb_sync u_bypass_sync
    (
        .clk   (main_clock),
        .rst_n (rst_n),
        .d     (~loop_bypass_n),
        .q     (bypass_sync)
    );

    // =========================================================
    // write port: first beat at K, address and second beat at K#
    logic [DATA_W-1:0] wr_d0;
    logic [LANES-1:0]  wr_l0;
    logic              wr_pend;

    // first beat with its lanes captured with the request
    always_ff @(posedge main_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend <= 1'b0;
            wr_d0   <= '0;
            wr_l0   <= '0;
        end
        else
        begin
            wr_pend <= ~write_request_n;  // see RULE6 see RULE13
            if (!write_request_n)
            begin
                wr_d0 <= write_data;      // see RULE6
                wr_l0 <= byte_write_n;    // see RULE12
            end
        end
    end

    // the held write burst; only a completed burst is buffered
    logic              wb_valid;
    logic [ADDR_W-1:0] wb_addr;
    logic [DATA_W-1:0] wb_d0;
    logic [DATA_W-1:0] wb_d1;
    logic [LANES-1:0]  wb_l0;
    logic [LANES-1:0]  wb_l1;

    // at K# the address and second beat complete the burst; the previous
    // buffered burst is committed to the array at this point, so the array
    // write lands on the following write cycle, keeping the buffer coherent
    always_ff @(posedge main_clock_inverted or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_valid <= 1'b0;
            wb_addr  <= '0;
            wb_d0    <= '0;
            wb_d1    <= '0;
            wb_l0    <= '0;
            wb_l1    <= '0;
        end
        else if (wr_pend)
        begin
            wb_valid <= 1'b1;
            wb_addr  <= address_inputs;   // see RULE7
            wb_d0    <= wr_d0;
            wb_l0    <= wr_l0;
            wb_d1    <= write_data;       // see RULE7
            wb_l1    <= byte_write_n;     // see RULE12
        end
    end

    // array commit of the older burst when a new write displaces it
    always_ff @(posedge main_clock_inverted)
    begin
        if (wr_pend && wb_valid)          // see RULE9 see RULE13
        begin
            mem[beat_addr(wb_addr, 1'b0)] <= lane_merge(mem[beat_addr(wb_addr, 1'b0)],
                                                        wb_d0, wb_l0);
            mem[beat_addr(wb_addr, 1'b1)] <= lane_merge(mem[beat_addr(wb_addr, 1'b1)],
                                                        wb_d1, wb_l1);
        end
    end

    // =========================================================
    // read port: address at K, beats after the latency
    qdb_rd_state_t     rd_state;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] rd_out_addr;
    logic              rd_lat1;

    // read sequencer; an idle cycle does not disturb a running burst
    always_ff @(posedge main_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_state <= QDB_RD_IDLE;
            rd_addr  <= '0;
            rd_lat1  <= 1'b0;
        end
        else
        begin
            case (rd_state)
                QDB_RD_IDLE, QDB_RD_BEAT1:
                begin
                    if (!read_request_n)  // see RULE1
                    begin
                        rd_addr  <= address_inputs;
                        rd_lat1  <= bypass_sync;
                        rd_state <= bypass_sync ? QDB_RD_BEAT0 : QDB_RD_WAIT; // see RULE19
                    end
                    else
                        rd_state <= QDB_RD_IDLE;
                end
                QDB_RD_WAIT:
                    rd_state <= QDB_RD_BEAT0; // see RULE3 see RULE5
                QDB_RD_BEAT0:
                begin
                    // a normal burst is two cycles old here, so the next may start
                    if (!read_request_n && !rd_lat1) // see RULE1
                    begin
                        rd_addr  <= address_inputs;
                        rd_lat1  <= bypass_sync;
                        rd_state <= bypass_sync ? QDB_RD_BEAT0 : QDB_RD_WAIT;
                    end
                    else
                        rd_state <= QDB_RD_BEAT1; // see RULE5 see RULE16
                end
                default:
                    rd_state <= QDB_RD_IDLE;
            endcase
        end
    end

    // coherent fetch: newest buffered write wins over array
    function automatic logic [DATA_W-1:0] fetch(input logic [ADDR_W-1:0] a, input logic b);
        logic [DATA_W-1:0] w;
        w = mem[beat_addr(a, b)];
        if (wb_valid && wb_addr == a)     // see RULE10 see RULE11
            w = b ? lane_merge(w, wb_d1, wb_l1) : lane_merge(w, wb_d0, wb_l0);
        return w;
    endfunction

    // burst address held for the output half cycles, so a request two
    // cycles on may reload rd_addr without corrupting the beats in flight
    always_ff @(posedge main_clock or negedge rst_n)
    begin
        if (!rst_n)
            rd_out_addr <= '0;
        else if (rd_state == QDB_RD_BEAT0)
            rd_out_addr <= rd_addr; // see RULE18
    end

    // output register: beat 0 at the K# inside the valid cycle and beat 1 at
    // the following K; the fetch is late, so a write that completed after
    // the read address is still seen
    logic [1:0] beat_pipe;

    always_ff @(negedge main_clock or negedge rst_n)
    begin
        if (!rst_n)
            beat_pipe[0] <= 1'b0;
        else
            beat_pipe[0] <= read_valid_flag; // see RULE3 see RULE15
    end

    always_ff @(posedge main_clock or negedge rst_n)
    begin
        if (!rst_n)
            beat_pipe[1] <= 1'b0;
        else
            beat_pipe[1] <= beat_pipe[0];
    end

    logic [DATA_W-1:0] rd_q0;
    logic [DATA_W-1:0] rd_q1;

    always_ff @(negedge main_clock or negedge rst_n)
    begin
        if (!rst_n)
            rd_q0 <= '0;
        else if (read_valid_flag)
            rd_q0 <= fetch(rd_out_addr, 1'b0);
    end

    always_ff @(posedge main_clock or negedge rst_n)
    begin
        if (!rst_n)
            rd_q1 <= '0;
        else if (beat_pipe[0])
            rd_q1 <= fetch(rd_out_addr, 1'b1);  // see RULE18
    end

    // output mux follows the half-cycle that owns the pins
    assign read_data    = beat_pipe[1] ? rd_q1 : rd_q0;
    assign read_data_oe = beat_pipe[0]; // see RULE21

    // valid leads the first beat by half a cycle and drops at the K that launches the last
    always_ff @(posedge main_clock or negedge rst_n)
    begin
        if (!rst_n)
            read_valid_flag <= 1'b0;
        else
            read_valid_flag <= (rd_state == QDB_RD_BEAT0); // see RULE17
    end

    // echo clocks follow the input clocks, same path delay as data
    assign echo_clock          = main_clock;          // see RULE4
    assign echo_clock_inverted = main_clock_inverted; // see RULE4

    // =========================================================
    // impedance settling counted on the input clock
    localparam int ZW = $clog2(ZQ_CYC + 1);
    logic [ZW-1:0] zq_cnt;
    logic          zq_done;

    always_ff @(posedge main_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zq_cnt         <= '0;
            zq_done        <= 1'b0;
            impedance_code <= `QDB_ZQ_MID;          // see RULE14
        end
        else if (!zq_done)
        begin
            zq_cnt <= zq_cnt + ZW'(1);
            if (zq_cnt == ZW'(ZQ_CYC - 1))
            begin
                zq_done        <= 1'b1;
                impedance_code <= `QDB_ZQ_FINAL;    // see RULE14
            end
        end
    end

    // status level carried into the system clock domain
    qdb_sync u_zq_sync
    (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (zq_done),
        .q     (impedance_ready)
    );
endmodule

`default_nettype wire

//--- logic/qdb_cfg.svh
`ifndef QDB_CFG_SVH
`define QDB_CFG_SVH

// array and bus sizing
`define QDB_ADDR_W        20
`define QDB_DATA_W        36
`define QDB_LANE_W        9
// read latency in main clock cycles with and without the loop
`define QDB_LAT_NORMAL    2
`define QDB_LAT_BYPASS    1
// impedance settling count in input clock cycles
`define QDB_ZQ_CYCLES     1024
`define QDB_ZQ_MID        4'h8
`define QDB_ZQ_FINAL      4'hf

`endif

//--- logic/qdb_pkg.sv
package qdb_pkg;
    // write request as captured on the rising main clock edge
    typedef struct packed {
        logic        valid;
        logic [35:0] data;
        logic [3:0]  lane_n;
    } qdb_beat_t;

    // completed write burst waiting in the write buffer
    typedef struct packed {
        logic        valid;
        logic [19:0] addr;
        logic [35:0] data0;
        logic [35:0] data1;
        logic [3:0]  lane0_n;
        logic [3:0]  lane1_n;
    } qdb_wbuf_t;

    typedef enum logic [1:0] {
        QDB_RD_IDLE,
        QDB_RD_WAIT,
        QDB_RD_BEAT0,
        QDB_RD_BEAT1
    } qdb_rd_state_t;
endpackage

//--- logic/qdb_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two flop level synchroniser; first stage is read only by the second
module qdb_sync
(
    input  wire logic clk,   // destination clock
    input  wire logic rst_n, // async reset, active low
    input  wire logic d,     // level from another domain
    output logic      q      // synchronised level
);
    logic meta;

    // =========================================================
    // synchroniser chain
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= 1'b0;
            q    <= 1'b0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

`default_nettype wire

//--- dv/qdb_sram_port_props.sv
`timescale 1ns/1ps
`default_nettype none

// ==========
// link side checks
module qdb_sram_port_props
#(
    parameter int ZQ_CYC = 1024 // settling count
)
(
    input wire logic       clk,             // sys clock
    input wire logic       rst_n,           // reset
    input wire logic       main_clock,      // link clock
    input wire logic       loop_bypass_n,   // bypass
    input wire logic       read_request_n,  // read req
    input wire logic       write_request_n, // write req
    input wire logic       read_data_oe,    // data enable
    input wire logic       echo_clock,      // echo
    input wire logic       read_valid_flag, // valid
    input wire logic [3:0] impedance_code,  // impedance
    input wire logic       impedance_ready  // settled
);
    int zq_cnt;
    // link rises since reset; saturates so it never wraps
    always_ff @(posedge main_clock or negedge rst_n)
    begin
        if (!rst_n)
            zq_cnt <= 0;
        else if (zq_cnt < ZQ_CYC + 4)
            zq_cnt <= zq_cnt + 1;
    end
    // bypass must be steady for four rises, else the synchroniser may disagree
    chk_valid_latency: assert property (@(posedge main_clock) disable iff (!rst_n)
        $rose(read_valid_flag) && loop_bypass_n && $past(loop_bypass_n, 4)
        |-> $past(read_request_n, 3) == 1'b0) else $error("valid without request");
    chk_read_answer: assert property (@(posedge main_clock) disable iff (!rst_n)
        !read_request_n && $past(read_request_n) && loop_bypass_n && $past(loop_bypass_n, 4)
        |-> ##2 !read_valid_flag ##1 read_valid_flag) else $error("read not answered");
    chk_valid_single: assert property (@(posedge main_clock) disable iff (!rst_n)
        $rose(read_valid_flag) |=> !read_valid_flag) else $error("valid too long");
    chk_valid_leads: assert property (@(posedge main_clock) disable iff (!rst_n)
        $rose(read_valid_flag) |-> read_data_oe ##1 !read_data_oe) else $error("beats misplaced");
    chk_data_idle: assert property (@(posedge main_clock) disable iff (!rst_n)
        !read_valid_flag && !$past(read_valid_flag) |-> !read_data_oe) else $error("stray data");
    chk_echo_follow: assert property (@(posedge clk) disable iff (!rst_n)
        echo_clock == main_clock) else $error("echo clock off");
    chk_zq_mid: assert property (@(posedge main_clock) disable iff (!rst_n)
        zq_cnt + 2 <= ZQ_CYC |-> impedance_code == 4'h8) else $error("impedance not mid");
    chk_zq_final: assert property (@(posedge main_clock) disable iff (!rst_n)
        zq_cnt > ZQ_CYC |-> impedance_code == 4'hf) else $error("impedance not final");
    chk_ready_final: assert property (@(posedge clk) disable iff (!rst_n)
        impedance_ready |-> impedance_code == 4'hf) else $error("ready too early");
    cover property (@(posedge main_clock) disable iff (!rst_n) $rose(read_valid_flag));
    cover property (@(posedge main_clock) disable iff (!rst_n) !write_request_n);
    cover property (@(posedge clk) disable iff (!rst_n) $rose(impedance_ready));
endmodule

bind qdb_sram_port qdb_sram_port_props #(.ZQ_CYC(ZQ_CYC)) qdb_sram_port_props_inst
(
    .clk, .rst_n, .main_clock, .loop_bypass_n, .read_request_n, .write_request_n,
    .read_data_oe, .echo_clock, .read_valid_flag, .impedance_code, .impedance_ready
);

`default_nettype wire

//--- dv/qdb_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========
// host controller: link clock pair and burst requests
module qdb_host_model
(
    output logic             main_clock,          // link clock
    output logic             main_clock_inverted, // complement
    output logic             read_request_n,      // read req
    output logic             write_request_n,     // write req
    output logic [19:0]      address_inputs,      // address
    output logic [35:0]      write_data,          // write beats
    output logic [3:0]       byte_write_n,        // lanes
    input  wire logic        read_valid_flag,     // valid
    input  wire logic        read_data_oe,        // enable
    input  wire logic [35:0] read_data            // read beats
);
    int lat = 2; // read latency expected, bench sets 1 for bypass
    initial
    begin
        main_clock = 1'b0;
        read_request_n = 1'b1;
        write_request_n = 1'b1;
        address_inputs = 20'h0;
        write_data = 36'h0;
        byte_write_n = 4'hf;
    end
    // free running pair, the device loop needs it steady
    always #62.5 main_clock = ~main_clock;
    assign main_clock_inverted = ~main_clock;
    // early write; address goes by nonblocking so it wins over a read's release
    task automatic wr(input logic [19:0] a, input logic [35:0] d0, d1, input logic [3:0] l0, l1);
        @(posedge main_clock);
        #1;
        write_request_n = 1'b0;
        write_data = d0;
        byte_write_n = l0;
        @(posedge main_clock);
        #1;
        write_request_n = 1'b1;
        address_inputs <= a;
        write_data = d1;
        byte_write_n = l1;
        @(posedge main_clock_inverted);
        #1;
        address_inputs = ~a;    // released lines show the inverse
        write_data = ~d1;
        byte_write_n = ~l1;
    endtask
    // one burst read; ok drops if valid or enable is off time
    task automatic rd(input logic [19:0] a, output logic [35:0] q0, q1, output logic ok);
        @(posedge main_clock);
        #1;
        read_request_n = 1'b0;
        address_inputs = a;
        @(posedge main_clock);
        #1;
        read_request_n = 1'b1;
        address_inputs = ~a;
        repeat (lat - 1) @(posedge main_clock);
        #1;
        ok = read_valid_flag === 1'b0;
        @(posedge main_clock);
        #1;
        ok &= read_valid_flag === 1'b1 && read_data_oe === 1'b0;
        @(posedge main_clock_inverted);
        #1;
        ok &= read_data_oe === 1'b1;
        q0 = read_data;
        @(posedge main_clock);
        #1;
        ok &= read_data_oe === 1'b1 && read_valid_flag === 1'b0;
        q1 = read_data;
        @(posedge main_clock_inverted);
        #1;
        ok &= read_data_oe === 1'b0;
    endtask
endmodule

`default_nettype wire

//--- dv/qdb_sram_port_bench.sv
`timescale 1ns/1ps
`default_nettype none

// ==========
// bench top
module qdb_sram_port_bench;
    localparam int ZQ = 16; // short settling keeps the run brief
    logic        clk, rst_n, loop_bypass_n, read_data_oe, echo_clock, echo_clock_inverted;
    logic        main_clock, main_clock_inverted, read_request_n, write_request_n;
    logic        read_valid_flag, impedance_ready;
    logic [19:0] address_inputs;
    logic [35:0] write_data, read_data;
    logic [3:0]  byte_write_n, impedance_code;
    int          err_count, checks_done;
    int          cycles = 0;
    qdb_sram_port #(.ZQ_CYC(ZQ)) qdb_sram_port_inst (.clk, .rst_n, .main_clock,
        .main_clock_inverted, .loop_bypass_n, .read_request_n, .write_request_n,
        .address_inputs, .write_data, .byte_write_n, .read_data, .read_data_oe, .echo_clock,
        .echo_clock_inverted, .read_valid_flag, .impedance_code, .impedance_ready);
    qdb_host_model qdb_host_model_inst (.main_clock, .main_clock_inverted, .read_request_n,
        .write_request_n, .address_inputs, .write_data, .byte_write_n, .read_valid_flag,
        .read_data_oe, .read_data);
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    // low lanes take the new byte
    function automatic logic [35:0] mrg(input logic [35:0] o, n, input logic [3:0] l);
        mrg = o;
        for (int i = 0; i < 4; i++)
            if (!l[i])
                mrg[i*9 +: 9] = n[i*9 +: 9];
    endfunction
    task automatic rdchk(input logic [19:0] a, input logic [35:0] e0, e1, input string m);
        logic [35:0] q0, q1;
        logic        ok;
        qdb_host_model_inst.rd(a, q0, q1, ok);
        check(ok, {m, " timing"});
        check(q0 === e0 && q1 === e1, m);
    endtask
    task automatic t_imped();
        check(impedance_code === 4'h8, "not mid");
        check(echo_clock === main_clock && echo_clock_inverted === main_clock_inverted,
            "echo clocks off");
        repeat (ZQ + 2) @(posedge main_clock);
        #1;
        check(impedance_code === 4'hf, "not final");
        repeat (8) @(posedge clk);
        #1;
        check(impedance_ready === 1'b1, "no ready");
    endtask
    task automatic t_buffer();
        qdb_host_model_inst.wr(20'h10, 36'h123456789, 36'h9abcdef01, 4'h0, 4'h0);
        rdchk(20'h10, 36'h123456789, 36'h9abcdef01, "buffer");
        qdb_host_model_inst.wr(20'h11, 36'h0a5a5a5a5, 36'h05a5a5a5a, 4'h0, 4'h0);
        rdchk(20'h11, 36'h0a5a5a5a5, 36'h05a5a5a5a, "next");
        rdchk(20'h10, 36'h123456789, 36'h9abcdef01, "kept");
    endtask
    // three bursts push the two oldest into the array; idle lines carry junk
    task automatic t_commit();
        logic [35:0] d;
        for (int i = 0; i < 3; i++)
        begin
            d = 36'h111111111 * 36'(i + 1);
            qdb_host_model_inst.wr(20'h20 + 20'(i), d, ~d, 4'h0, 4'h0);
        end
        repeat (4) @(posedge main_clock);
        for (int i = 0; i < 3; i++)
        begin
            d = 36'h111111111 * 36'(i + 1);
            rdchk(20'h20 + 20'(i), d, ~d, "commit");
        end
    endtask
    // reads two cycles apart, the tightest spacing the host may use
    task automatic t_pair();
        logic [35:0] a0, a1, b0, b1;
        logic        oka, okb;
        fork
            qdb_host_model_inst.rd(20'h20, a0, a1, oka);
            begin
                repeat (2) @(posedge main_clock);
                qdb_host_model_inst.rd(20'h21, b0, b1, okb);
            end
        join
        check(oka && okb, "paired reads timing");
        check(a0 === 36'h111111111 && a1 === ~36'h111111111 && b0 === 36'h222222222
            && b1 === ~36'h222222222, "paired reads data");
    endtask
    task automatic t_mask();
        qdb_host_model_inst.wr(20'h30, 36'h0, 36'hfffffffff, 4'h0, 4'h0);
        qdb_host_model_inst.wr(20'h30, 36'hfffffffff, 36'h0, 4'h5, 4'ha);
        rdchk(20'h30, mrg(36'h0, 36'hfffffffff, 4'h5), mrg(36'hfffffffff, 36'h0, 4'ha),
            "lanes buf");
        qdb_host_model_inst.wr(20'h31, 36'h0, 36'h0, 4'hf, 4'hf);
        rdchk(20'h30, mrg(36'h0, 36'hfffffffff, 4'h5), mrg(36'hfffffffff, 36'h0, 4'ha),
            "lanes arr");
    endtask
    task automatic t_same();
        logic [35:0] q0, q1;
        logic        ok;
        // the write is issued one cycle behind the read of the same address
        fork
            qdb_host_model_inst.rd(20'h40, q0, q1, ok);
            begin
                @(posedge main_clock);
                qdb_host_model_inst.wr(20'h40, 36'h0c0ffee00, 36'h0beef0000, 4'h0, 4'h0);
            end
        join
        check(ok, "ports interfere");
        check(q0 === 36'h0c0ffee00 && q1 === 36'h0beef0000, "stale data");
    endtask
    task automatic t_bypass();
        @(posedge main_clock);
        #1;
        loop_bypass_n = 1'b0;
        repeat (4) @(posedge main_clock);
        qdb_host_model_inst.lat = 1;
        rdchk(20'h40, 36'h0c0ffee00, 36'h0beef0000, "bypass");
        qdb_host_model_inst.lat = 2;
        @(posedge main_clock);
        #1;
        loop_bypass_n = 1'b1;
        repeat (4) @(posedge main_clock);
    endtask
    always #10 clk = ~clk;
    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            results();
        end
    end
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        loop_bypass_n = 1'b1;
        err_count = 0;
        checks_done = 0;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_imped();
        t_buffer();
        t_commit();
        t_pair();
        t_mask();
        t_same();
        t_bypass();
        results();
    end
endmodule

`default_nettype wire
